// >>> design/sdram_pin_params.svh
/*
 Constants for the command pin decoder: pin widths, address bit positions,
 burst lengths and the precharge count.
 Assumes inclusion by the package and the design modules.
*/
`ifndef SDRAM_PIN_PARAMS_SVH
`define SDRAM_PIN_PARAMS_SVH
`define NUM_BANKS 8
`define BANK_W 3
`define ADDR_W 14
`define ROW_W 14
`define COL_W 10
`define PRE_FLAG_BIT 10
`define CHOP_BIT 12
`define LEFT_W 3
`define PAIRS_FULL 3'h4
`define PAIRS_CHOP 3'h2
`define PRE_CNT_W 2
`define PRE_TICKS 2'h2
`endif

// >>> design/sdram_pin_pkg.sv
/*
 Types shared by the command pin decoder: command codes, bank states,
 the pin bundle, the decoded command and the decoder state.
 Assumes the params header is on the include path.
*/
package sdram_pin_pkg;
`include "sdram_pin_params.svh"

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_OPEN_ROW = 3'b001,
		CMD_PRECHARGE = 3'b010,
		CMD_READ = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_OTHER = 3'b101
	} cmd_t;

	typedef enum logic [1:0] {
		BANK_IDLE = 2'b00,
		BANK_ACTIVE = 2'b01,
		BANK_PRECHARGING = 2'b10
	} bank_state_t;

	typedef struct packed {
		logic ck;
		logic ck_c;
		logic cke;
		logic cs_n;
		logic row_n;
		logic col_n;
		logic wr_n;
		logic [`BANK_W-1:0] bank;
		logic [`ADDR_W-1:0] addr;
	} pin_bus_t;

	typedef struct packed {
		cmd_t kind;
		logic [`BANK_W-1:0] bank;
		logic [`ROW_W-1:0] row;
		logic [`COL_W-1:0] col;
		logic auto_pre;
		logic chop;
		logic pre_all;
	} cmd_info_t;

	typedef struct packed {
		logic ck_prev;
		logic susp;
		logic low_pwr;
		logic lp_entry;
		logic strobe;
		cmd_info_t cmd;
		logic burst_on;
		logic burst_rd;
		logic burst_ap;
		logic [`BANK_W-1:0] burst_bank;
		logic [`LEFT_W-1:0] burst_left;
		bank_state_t [`NUM_BANKS-1:0] banks;
		logic [`NUM_BANKS-1:0][`PRE_CNT_W-1:0] pre_cnt;
	} core_state_t;
endpackage

// >>> design/pin_sync.sv
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes asynchronous inputs; output follows once stages two and three agree.
*/
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pins in, filtered level out
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] d_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] filt;
	} sync_state_t;

	sync_state_t st_ff;
	sync_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = d_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (st_ff.s2 == st_ff.s3) begin
			nxt_st.filt = st_ff.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign d_out = st_ff.filt;

	// Filter holds unless the late stages agree
	property p_filter_hold;
		@(posedge clk) disable iff (!rst_b)
		(rst_b && st_ff.s2 != st_ff.s3) |=> $stable(st_ff.filt);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter moved without agreement");
endmodule

// >>> design/ddr_out_align.sv
/*
 Read data aligner: one data item per clock pair crossing.
 Assumes crossing pulses from the decoder and a freeze level while suspended.
*/
`timescale 1ns/10ps
module ddr_out_align #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Crossing events and suspend
	input wire logic rise_x,
	input wire logic fall_x,
	input wire logic freeze,
	// Beat pair in
	input wire logic load,
	input wire logic [2*W-1:0] word,
	// Data out
	output logic [W-1:0] dq,
	output logic dq_oe
);
	typedef struct packed {
		logic [W-1:0] hi;
		logic [W-1:0] dq;
		logic oe;
	} out_state_t;

	out_state_t st_ff;
	out_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (load) begin
			nxt_st.dq = word[W-1:0];
			nxt_st.hi = word[2*W-1:W];
			nxt_st.oe = 1'b1;
		end else if (!freeze) begin
			if (fall_x && st_ff.oe) begin
				nxt_st.dq = st_ff.hi;
			end else if (rise_x) begin
				nxt_st.oe = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dq = st_ff.dq;
	assign dq_oe = st_ff.oe;

	// Second item follows on the falling crossing
	property p_fall_item;
		@(posedge clk) disable iff (!rst_b)
		(fall_x && st_ff.oe && !freeze && !load) |=> (dq == $past(st_ff.hi));
	endproperty
	a_fall_item: assert property (p_fall_item) else $error("falling crossing item wrong");
endmodule

// >>> design/sdram_cmd_decode.sv
/*
 Command and address pin decoder of a DDR synchronous DRAM: crossing
 capture, clock-enable suspend, bank tracking and read data alignment.
 Assumes the controller drives all pins; they arrive asynchronous to CLOCK.
*/
`timescale 1ns/10ps
`include "sdram_pin_params.svh"
module sdram_cmd_decode
	import sdram_pin_pkg::*;
#(
	parameter int DQ_W = 8
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// Clock pair and command pins
	input wire logic CK_TRUE,
	input wire logic CLOCK_COMPLEMENT,
	input wire logic CLOCK_ENABLE,
	input wire logic CHIP_SELECT_N,
	input wire logic ROW_STROBE_N,
	input wire logic COL_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic [`BANK_W-1:0] BANK_SELECT,
	input wire logic [`ADDR_W-1:0] ADDRESS_LINES,
	// Decoded command
	output cmd_info_t CMD_INFO,
	output logic CMD_STROBE,
	// Bank and power state
	output logic [`NUM_BANKS-1:0] BANK_OPEN,
	output logic ALL_IDLE,
	output logic SUSPENDED,
	output logic LOW_POWER,
	output logic LOW_POWER_ENTRY,
	// Read data
	output logic RD_REQ,
	input wire logic [2*DQ_W-1:0] RD_WORD,
	output logic [DQ_W-1:0] DQ_OUT,
	output logic DQ_OE
);
	localparam pin_bus_t PIN_RST = '{
		ck: 1'b0, ck_c: 1'b1, cke: 1'b0, cs_n: 1'b1, row_n: 1'b1,
		col_n: 1'b1, wr_n: 1'b1, bank: '0, addr: '0};

	core_state_t st_ff;
	core_state_t nxt_st;
	pin_bus_t raw;
	pin_bus_t pins;
	logic [$bits(pin_bus_t)-1:0] pins_vec;
	logic rise_x;
	logic fall_x;
	logic take;
	logic all_idle;
	logic burst_end;
	cmd_t dec;
	logic [`NUM_BANKS-1:0] idle_vec;
	bank_state_t [`NUM_BANKS-1:0] nxt_bank;
	logic [`NUM_BANKS-1:0][`PRE_CNT_W-1:0] nxt_cnt;

	assign raw = '{ck: CK_TRUE, ck_c: CLOCK_COMPLEMENT, cke: CLOCK_ENABLE,
		cs_n: CHIP_SELECT_N, row_n: ROW_STROBE_N, col_n: COL_STROBE_N,
		wr_n: WRITE_STROBE_N, bank: BANK_SELECT, addr: ADDRESS_LINES};

	pin_sync #(
		.W($bits(pin_bus_t)),
		.RST_VAL(PIN_RST)
	) u_sync (
		.clk(CLOCK),
		.rst_b(RST_B),
		.d_in(raw),
		.d_out(pins_vec)
	);

	assign pins = pin_bus_t'(pins_vec);

	// Crossing events
	assign rise_x = pins.ck & ~st_ff.ck_prev & ~pins.ck_c;
	assign fall_x = ~pins.ck & st_ff.ck_prev & pins.ck_c;
	assign take = rise_x & ~st_ff.susp;
	assign burst_end = take & st_ff.burst_on & (st_ff.burst_left == `LEFT_W'(1));
	assign all_idle = &idle_vec;

	// Command truth table
	always_comb begin
		dec = CMD_NONE;
		if (!pins.cs_n) begin
			case ({pins.row_n, pins.col_n, pins.wr_n})
			3'b011: begin
				dec = CMD_OPEN_ROW;
			end
			3'b010: begin
				dec = CMD_PRECHARGE;
			end
			3'b101: begin
				dec = CMD_READ;
			end
			3'b100: begin
				dec = CMD_WRITE;
			end
			3'b111: begin
				dec = CMD_NONE;
			end
			default: begin
				dec = CMD_OTHER;
			end
			endcase
		end
	end

	// Per-bank state
	for (genvar i = 0; i < `NUM_BANKS; i++) begin : g_bank
		logic hit;
		logic ap_close;
		assign hit = (pins.bank == `BANK_W'(i));
		assign ap_close = burst_end & st_ff.burst_ap & (st_ff.burst_bank == `BANK_W'(i));
		assign idle_vec[i] = (st_ff.banks[i] == BANK_IDLE);
		assign BANK_OPEN[i] = (st_ff.banks[i] == BANK_ACTIVE);
		always_comb begin
			nxt_bank[i] = st_ff.banks[i];
			nxt_cnt[i] = st_ff.pre_cnt[i];
			case (st_ff.banks[i])
			BANK_IDLE: begin
				if (take && dec == CMD_OPEN_ROW && hit) begin
					nxt_bank[i] = BANK_ACTIVE;
				end
			end
			BANK_ACTIVE: begin
				if ((take && dec == CMD_PRECHARGE && (hit || pins.addr[`PRE_FLAG_BIT]))
					|| ap_close) begin
					nxt_bank[i] = BANK_PRECHARGING;
					nxt_cnt[i] = `PRE_TICKS;
				end
			end
			BANK_PRECHARGING: begin
				if (take) begin
					if (st_ff.pre_cnt[i] == '0) begin
						nxt_bank[i] = BANK_IDLE;
					end else begin
						nxt_cnt[i] = st_ff.pre_cnt[i] - `PRE_CNT_W'(1);
					end
				end
			end
			default: begin
				nxt_bank[i] = BANK_IDLE;
			end
			endcase
		end
	end

	// Decoder state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.ck_prev = pins.ck;
		nxt_st.strobe = 1'b0;
		nxt_st.lp_entry = 1'b0;
		nxt_st.banks = nxt_bank;
		nxt_st.pre_cnt = nxt_cnt;
		if (take) begin
			if (st_ff.burst_on) begin
				if (burst_end) begin
					nxt_st.burst_on = 1'b0;
				end else begin
					nxt_st.burst_left = st_ff.burst_left - `LEFT_W'(1);
				end
			end
			if (dec != CMD_NONE) begin
				nxt_st.strobe = 1'b1;
				nxt_st.cmd.kind = dec;
				nxt_st.cmd.bank = pins.bank;
				nxt_st.cmd.pre_all = (dec == CMD_PRECHARGE) && pins.addr[`PRE_FLAG_BIT];
			end
			if (dec == CMD_OPEN_ROW) begin
				nxt_st.cmd.row = pins.addr[`ROW_W-1:0];
			end
			if (dec == CMD_READ || dec == CMD_WRITE) begin
				nxt_st.cmd.col = pins.addr[`COL_W-1:0];
				nxt_st.cmd.auto_pre = pins.addr[`PRE_FLAG_BIT];
				nxt_st.cmd.chop = ~pins.addr[`CHOP_BIT];
				nxt_st.burst_on = 1'b1;
				nxt_st.burst_rd = (dec == CMD_READ);
				nxt_st.burst_ap = pins.addr[`PRE_FLAG_BIT];
				nxt_st.burst_bank = pins.bank;
				nxt_st.burst_left = pins.addr[`CHOP_BIT] ? `PAIRS_FULL : `PAIRS_CHOP;
			end
			if (!pins.cke) begin
				nxt_st.susp = 1'b1;
				if (all_idle && dec == CMD_NONE) begin
					nxt_st.low_pwr = 1'b1;
					nxt_st.lp_entry = 1'b1;
				end
			end
		end else if (rise_x && pins.cke) begin
			nxt_st.susp = 1'b0;
			nxt_st.low_pwr = 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Read data path
	assign RD_REQ = take & st_ff.burst_on & st_ff.burst_rd;

	ddr_out_align #(
		.W(DQ_W)
	) u_out (
		.clk(CLOCK),
		.rst_b(RST_B),
		.rise_x(rise_x),
		.fall_x(fall_x),
		.freeze(st_ff.susp),
		.load(RD_REQ),
		.word(RD_WORD),
		.dq(DQ_OUT),
		.dq_oe(DQ_OE)
	);

	assign CMD_INFO = st_ff.cmd;
	assign CMD_STROBE = st_ff.strobe;
	assign ALL_IDLE = all_idle;
	assign SUSPENDED = st_ff.susp;
	assign LOW_POWER = st_ff.low_pwr;
	assign LOW_POWER_ENTRY = st_ff.lp_entry;

	// Checks
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);

	property p_crossing_only;
		CMD_STROBE |-> $past(rise_x);
	endproperty
	a_crossing_only: assert property (p_crossing_only) else $error("strobe off crossing");

	property p_freeze;
		(st_ff.susp && !rise_x) |=> $stable(st_ff.burst_left) && $stable(DQ_OUT);
	endproperty
	a_freeze: assert property (p_freeze) else $error("burst moved while suspended");

	property p_low_power;
		(take && !pins.cke && all_idle && dec == CMD_NONE) |=> LOW_POWER && LOW_POWER_ENTRY;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low power not entered");

	property p_bank_field;
		CMD_STROBE |-> (CMD_INFO.bank == $past(pins.bank));
	endproperty
	a_bank_field: assert property (p_bank_field) else $error("wrong bank");

	property p_row_addr;
		(take && dec == CMD_OPEN_ROW) |=> (CMD_INFO.row == $past(pins.addr));
	endproperty
	a_row_addr: assert property (p_row_addr) else $error("row address wrong");

	property p_auto_pre;
		(take && (dec == CMD_READ || dec == CMD_WRITE)) |=>
			(CMD_INFO.auto_pre == $past(pins.addr[`PRE_FLAG_BIT]))
			&& (CMD_INFO.chop == !$past(pins.addr[`CHOP_BIT]));
	endproperty
	a_auto_pre: assert property (p_auto_pre) else $error("flag bits wrong");

	property p_pre_all;
		(take && dec == CMD_PRECHARGE && pins.addr[`PRE_FLAG_BIT]) |=> (BANK_OPEN == '0);
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("bank left open");

	property p_chop_len;
		(take && dec == CMD_READ && !pins.addr[`CHOP_BIT]) |=> (st_ff.burst_left == `PAIRS_CHOP);
	endproperty
	a_chop_len: assert property (p_chop_len) else $error("chop length wrong");

	property p_deselect;
		(rise_x && pins.cs_n) |=> !CMD_STROBE;
	endproperty
	a_deselect: assert property (p_deselect) else $error("command while deselected");

	property p_open_row;
		(take && !pins.cs_n && !pins.row_n && pins.col_n && pins.wr_n
			&& st_ff.banks[pins.bank] == BANK_IDLE)
			|=> CMD_STROBE && CMD_INFO.kind == CMD_OPEN_ROW && BANK_OPEN[CMD_INFO.bank];
	endproperty
	a_open_row: assert property (p_open_row) else $error("open row not done");

	property p_precharge;
		(take && !pins.cs_n && !pins.row_n && pins.col_n && !pins.wr_n)
			|=> CMD_INFO.kind == CMD_PRECHARGE && !BANK_OPEN[CMD_INFO.bank];
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge not done");

	property p_column;
		(take && !pins.cs_n && pins.row_n && !pins.col_n)
			|=> (CMD_INFO.kind == ($past(pins.wr_n) ? CMD_READ : CMD_WRITE)) && st_ff.burst_on;
	endproperty
	a_column: assert property (p_column) else $error("column access wrong");
endmodule

// >>> test/ctrl_model.sv
/*
 Memory controller model: drives the clock pair, clock enable and command pins.
 Assumes the bench calls issue once for each clock pair period it wants.
*/
`timescale 1ns/10ps
`include "sdram_pin_params.svh"
module ctrl_model
	import sdram_pin_pkg::*;
(
	// System clock
	input wire logic clk,
	// Pins to the device
	output pin_bus_t pins
);
	initial begin
		pins = '0;
		pins.ck_c = 1'b1;
		pins.cs_n = 1'b1;
		pins.row_n = 1'b1;
		pins.col_n = 1'b1;
		pins.wr_n = 1'b1;
	end
	// One clock pair period carrying one command
	task automatic issue(input logic cke, input logic [3:0] c,
		input logic [`BANK_W-1:0] ba, input logic [`ADDR_W-1:0] a);
		@(posedge clk);
		pins.cke <= cke;
		{pins.cs_n, pins.row_n, pins.col_n, pins.wr_n} <= c;
		pins.bank <= ba;
		pins.addr <= a;
		repeat (3) @(posedge clk);
		pins.ck <= 1'b1;
		pins.ck_c <= 1'b0;
		repeat (3) @(posedge clk);
		// Released command lines go high; bank and address lines show inverted values
		{pins.cs_n, pins.row_n, pins.col_n, pins.wr_n} <= 4'hf;
		pins.bank <= ~ba;
		pins.addr <= ~a;
		repeat (3) @(posedge clk);
		pins.ck <= 1'b0;
		pins.ck_c <= 1'b1;
		repeat (5) @(posedge clk);
	endtask
endmodule

// >>> test/sdram_cmd_decode_tb.sv
/*
 Self-checking bench for the command pin decoder.
 Assumes the controller model drives all pins and the bench supplies read words.
*/
`timescale 1ns/10ps
`include "sdram_pin_params.svh"
module sdram_cmd_decode_tb
	import sdram_pin_pkg::*;
;
	localparam logic [3:0] OPN = 4'h3;
	localparam logic [3:0] PRE = 4'h2;
	localparam logic [3:0] RDC = 4'h5;
	localparam logic [3:0] WRC = 4'h4;
	localparam logic [3:0] NOP = 4'h7;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	pin_bus_t pins;
	cmd_info_t cmd_info;
	cmd_info_t last;
	logic cmd_strobe, all_idle, suspended, low_power, lp_entry, rd_req, dq_oe;
	logic pend = 1'b0;
	logic [7:0] bank_open;
	logic [7:0] dq_out;
	logic [7:0] exp_dq;
	logic [7:0] exp_hi = 8'h00;
	int hi_wait = 0;
	logic [15:0] rd_word = 16'h0000;
	logic [13:0] row;
	logic [9:0] col;
	int failures = 0;
	int checked = 0;
	int strobes = 0;
	int lp_entries = 0;
	int rd_reqs = 0;
	logic [3:0] acc_c [3] = '{RDC, RDC, WRC};
	logic acc_chop_n [3] = '{1'b1, 1'b0, 1'b0};
	logic acc_ap [3] = '{1'b0, 1'b1, 1'b0};
	int acc_reqs [3] = '{4, 2, 0};

	always #25 clock = ~clock;

	ctrl_model ctrl_model_inst (.clk(clock), .pins(pins));

	sdram_cmd_decode #(.DQ_W(8)) sdram_cmd_decode_inst (
		.CLOCK(clock), .RST_B(rst_b), .CK_TRUE(pins.ck), .CLOCK_COMPLEMENT(pins.ck_c),
		.CLOCK_ENABLE(pins.cke), .CHIP_SELECT_N(pins.cs_n), .ROW_STROBE_N(pins.row_n),
		.COL_STROBE_N(pins.col_n), .WRITE_STROBE_N(pins.wr_n), .BANK_SELECT(pins.bank),
		.ADDRESS_LINES(pins.addr), .CMD_INFO(cmd_info), .CMD_STROBE(cmd_strobe),
		.BANK_OPEN(bank_open), .ALL_IDLE(all_idle), .SUSPENDED(suspended),
		.LOW_POWER(low_power), .LOW_POWER_ENTRY(lp_entry), .RD_REQ(rd_req),
		.RD_WORD(rd_word), .DQ_OUT(dq_out), .DQ_OE(dq_oe));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	function automatic cmd_t exp_kind(input logic [3:0] c);
		case (c)
			OPN: return CMD_OPEN_ROW;
			PRE: return CMD_PRECHARGE;
			RDC: return CMD_READ;
			WRC: return CMD_WRITE;
			default: return CMD_OTHER;
		endcase
	endfunction

	// Monitor of strobes, entries, read requests and read data
	always @(posedge clock) begin
		if (cmd_strobe === 1'b1) begin
			strobes++;
			last = cmd_info;
		end
		if (lp_entry === 1'b1) lp_entries++;
		if (pend === 1'b1) begin
			chk(32'(dq_out), 32'(exp_dq));
			chk(32'(dq_oe), 32'h1);
			hi_wait <= 6;
		end else if (hi_wait == 1) begin
			// High item follows on the falling crossing
			chk(32'(dq_out), 32'(exp_hi));
			hi_wait <= 0;
		end else if (hi_wait > 1) begin
			hi_wait <= hi_wait - 1;
		end
		if (rd_req === 1'b1) begin
			rd_reqs++;
			exp_hi <= rd_word[15:8];
		end
		pend <= rd_req;
		exp_dq <= rd_word[7:0];
		rd_word <= 16'($urandom);
	end

	task automatic cmd(input logic cke, input logic [3:0] c, input logic [2:0] ba,
		input logic [13:0] a);
		strobes = 0;
		ctrl_model_inst.issue(cke, c, ba, a);
	endtask

	task automatic idle(input int n);
		repeat (n) cmd(1'b1, NOP, 3'h0, 14'h0000);
	endtask

	initial begin
		void'($urandom(92));
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		repeat (6) @(posedge clock);
		chk(32'(cmd_info.kind), 32'(CMD_NONE));
		chk(32'(bank_open), 32'h0);
		chk(32'(all_idle), 32'h1);
		// Deselected open row is ignored
		cmd(1'b1, 4'hb, 3'h4, 14'h1555);
		chk(32'(strobes), 32'h0);
		chk(32'(bank_open), 32'h0);
		for (int i = 0; i < 8; i++) begin
			row = 14'($urandom);
			cmd(1'b1, OPN, 3'(i), row);
			chk(32'(strobes), 32'h1);
			chk(32'(last.kind), 32'(exp_kind(OPN)));
			chk(32'(last.bank), 32'(i));
			chk(32'(last.row), 32'(row));
			chk(32'(bank_open[i]), 32'h1);
		end
		cmd(1'b1, 4'h1, 3'h0, 14'h0000);
		chk(32'(last.kind), 32'(CMD_OTHER));
		for (int i = 0; i < 3; i++) begin
			col = 10'($urandom);
			rd_reqs = 0;
			cmd(1'b1, acc_c[i], 3'(i), {1'b0, acc_chop_n[i], 1'b1, acc_ap[i], col});
			chk(32'(last.kind), 32'(exp_kind(acc_c[i])));
			chk(32'(last.col), 32'(col));
			chk(32'(last.chop), 32'(!acc_chop_n[i]));
			chk(32'(last.auto_pre), 32'(acc_ap[i]));
			idle(6);
			chk(32'(rd_reqs), 32'(acc_reqs[i]));
			chk(32'(dq_oe), 32'h0);
			chk(32'(bank_open[i]), 32'(!acc_ap[i]));
		end
		cmd(1'b1, PRE, 3'h2, 14'h0000);
		chk(32'(bank_open), 32'hf9);
		cmd(1'b1, PRE, 3'($urandom), 14'h0400);
		chk(32'(last.pre_all), 32'h1);
		chk(32'(bank_open), 32'h0);
		idle(4);
		chk(32'(all_idle), 32'h1);
		// Clock enable low with all banks idle
		cmd(1'b0, NOP, 3'h0, 14'h0000);
		chk(32'(suspended), 32'h1);
		chk(32'(low_power), 32'h1);
		chk(32'(lp_entries), 32'h1);
		cmd(1'b0, OPN, 3'h5, 14'h0123);
		chk(32'(strobes), 32'h0);
		chk(32'(bank_open), 32'h0);
		idle(1);
		chk(32'(suspended), 32'h0);
		chk(32'(low_power), 32'h0);
		cmd(1'b1, OPN, 3'h5, 14'h0123);
		cmd(1'b0, NOP, 3'h0, 14'h0000);
		chk(32'(suspended), 32'h1);
		chk(32'(low_power), 32'h0);
		chk(32'(lp_entries), 32'h1);
		idle(1);
		chk(32'(bank_open), 32'h20);
		print_verdict();
	end

	initial begin
		#(50 * 6000);
		failures++;
		print_verdict();
	end
endmodule
